//--- pkg/osb_map.vh
// register offsets, field positions, reset values and timing counts of the stop sequencer
// assumes a 25 MHz clock and plain register port
`ifndef OSB_MAP_VH
`define OSB_MAP_VH
`define OSB_A_STOP_METHOD 4'h0
`define OSB_A_PLUG_TORQUE 4'h1
`define OSB_A_OUT_ALLOC 4'h2
`define OSB_A_SON_WAIT 4'h3
`define OSB_A_BASIC_WAIT 4'h4
`define OSB_A_BRK_SPEED 4'h5
`define OSB_A_BRK_TIME 4'h6
`define OSB_A_BASIC_FUNC 4'h7
`define OSB_A_STATUS 4'h8
`define OSB_A_TORQUE_OUT 4'h9
`define OSB_RST_STOP_METHOD 4'h0
`define OSB_RST_PLUG_TORQUE 9'h12c
`define OSB_MAX_PLUG_TORQUE 9'h12c
`define OSB_RST_OUT_ALLOC 12'hfff
`define OSB_RST_SON_WAIT 12'h000
`define OSB_RST_BASIC_WAIT 9'h000
`define OSB_MAX_BASIC_WAIT 9'h1f4
`define OSB_RST_BRK_SPEED 7'h64
`define OSB_MIN_BRK_SPEED 7'h0a
`define OSB_MAX_BRK_SPEED 7'h64
`define OSB_RST_BRK_TIME 7'h32
`define OSB_MIN_BRK_TIME 7'h0a
`define OSB_MAX_BRK_TIME 7'h64
`define OSB_RST_BASIC_FUNC 4'h0
`define OSB_BF_PWRLOSS 3
`define OSB_FN_BRAKE 4'h4
`define OSB_CLK_KHZ 25000
`define OSB_MS_CYCLES (`OSB_CLK_KHZ / 1000 * 1000)
`define OSB_TICK_MAX 15'h61a7
`define OSB_SON_LIMIT 12'h7d0
`define OSB_SM_DYN_COAST 4'h0
`define OSB_UNIT_MS_LAST 10'h009
`define OSB_FN_COUNT 4'hc
`define OSB_SM_COAST 4'h1
`define OSB_SM_LAST 4'h5
`endif

//--- design/osb_ms_tick.v
// millisecond tick divider for the stop sequencer
// assumes one 25 MHz clock, synchronous active-low reset
`timescale 1ns/1ps
`include "osb_map.vh"
module osb_ms_tick (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // one-cycle pulse every millisecond
    output reg tick_ms
);
    reg [14:0] cnt_q;
    always @(posedge clock) begin
        if (!rst_n) begin
            cnt_q <= 15'h0000;
            tick_ms <= 1'b0;
        end else if (cnt_q == `OSB_TICK_MAX) begin
            cnt_q <= 15'h0000;
            tick_ms <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 15'h0001;
            tick_ms <= 1'b0;
        end
    end
endmodule

//--- design/osb_stop_sequencer.v
// stop sequencer: overtravel and servo-off stop method, end state, brake interlock, power-loss policy
// assumes 25 MHz clock, synchronous inputs, plain register port with read data one cycle later
// Operation
// - code 0: dynamic brake, then coast
// - code 1: coast to halt, then coast
// - codes 2-5 plug brake; servo-off dynamic or coast
// - end state coast 0-3, zero clamp 4-5
// - zero clamp holds zero position reference
// - stop method latched after each reset only
// - torque limit percent of rated torque
// - brake output low releases, high applies
// - brake unassigned to slots at reset; brake_interlock_out still driven
// - digit code 4 routes brake to slot
// - digit selects one of twelve functions
// - servo-off stop end held by signed/basic waits
// - running stop uses wait speed and time
// - power loss: continue if 0, alarm if 1
`timescale 1ns/1ps
`include "osb_map.vh"
module osb_stop_sequencer (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // register port
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    // drive state inputs
    input wire servo_on,
    input wire alarm_in,
    input wire forward_limit_input,
    input wire reverse_limit_input,
    input wire main_power_lost,
    input wire [6:0] motor_speed_rpm,
    // sources for the output slots, indexed by function code 0..11
    input wire [11:0] out_sources,
    // read data, one cycle after the read strobe
    output reg [15:0] reg_rdata,
    // power stage commands
    output reg dynamic_brake,
    output reg power_enable,
    output reg plug_brake,
    output reg zero_clamp,
    output reg [8:0] torque_limit_pct,
    output reg power_loss_alarm,
    // output slots, active low, with brake interlock routed when allocated
    output reg [2:0] slot_out_n,
    output reg brake_interlock_out
);
    localparam [2:0] ST_RUN = 3'h0;
    localparam [2:0] ST_LIMIT_STOP = 3'h1;
    localparam [2:0] ST_SOFF_STOP = 3'h2;
    localparam [2:0] ST_COAST = 3'h3;
    localparam [2:0] ST_CLAMP = 3'h4;
    localparam [2:0] ST_IDLE = 3'h5;

    // power-up value only: rst_n leaves the stored method alone
    reg [3:0] stop_method_select_q = `OSB_RST_STOP_METHOD;
    reg [3:0] stop_method_act_q;
    reg [8:0] plug_brake_torque_limit_q;
    reg [11:0] output_function_alloc_q;
    reg [11:0] servo_on_wait_time_q;
    reg [8:0] basic_wait_time_q;
    reg [6:0] brake_wait_speed_q;
    reg [6:0] brake_wait_time_q;
    reg [3:0] basic_function_select_q;
    reg [2:0] state_q;
    reg boot_q;
    reg [12:0] wait_q;
    reg [9:0] sub_q;
    reg brake_hold_q;
    wire tick_ms;
    wire overtravel = forward_limit_input | reverse_limit_input;
    wire stop_req = !servo_on | alarm_in;
    wire soff_dyn = (stop_method_act_q == `OSB_SM_DYN_COAST) || !stop_method_act_q[0];
    wire to_clamp = stop_method_act_q[2];
    wire plug_mode = (stop_method_act_q > `OSB_SM_COAST);
    wire slow = motor_speed_rpm < brake_wait_speed_q;
    // a negative servo-on wait adds no delay after the brake
    wire [11:0] son_mag = servo_on_wait_time_q[11] ? (12'h000 - servo_on_wait_time_q) : servo_on_wait_time_q;
    wire [12:0] soff_wait_ms = {1'b0, servo_on_wait_time_q[11] ? 12'h000 : son_mag};

    osb_ms_tick u_tick (
        .clock(clock),
        .rst_n(rst_n),
        .tick_ms(tick_ms)
    );

    // register writes; out-of-range values are clamped to the documented range
    always @(posedge clock) begin
        if (!rst_n) begin
            plug_brake_torque_limit_q <= `OSB_RST_PLUG_TORQUE;
            output_function_alloc_q <= `OSB_RST_OUT_ALLOC;
            servo_on_wait_time_q <= `OSB_RST_SON_WAIT;
            basic_wait_time_q <= `OSB_RST_BASIC_WAIT;
            brake_wait_speed_q <= `OSB_RST_BRK_SPEED;
            brake_wait_time_q <= `OSB_RST_BRK_TIME;
            basic_function_select_q <= `OSB_RST_BASIC_FUNC;
        end else if (reg_wr) begin
            case (reg_addr)
                `OSB_A_PLUG_TORQUE: begin
                    plug_brake_torque_limit_q <= (reg_wdata[8:0] > `OSB_MAX_PLUG_TORQUE || reg_wdata[15:9] != 7'h00)
                        ? `OSB_MAX_PLUG_TORQUE : reg_wdata[8:0];
                end
                `OSB_A_OUT_ALLOC: output_function_alloc_q <= reg_wdata[11:0];
                `OSB_A_SON_WAIT: begin
                    // signed ms, clamped to +/-2000
                    if (!reg_wdata[15] && reg_wdata[14:0] > {3'h0, `OSB_SON_LIMIT})
                        servo_on_wait_time_q <= `OSB_SON_LIMIT;
                    else if (reg_wdata[15] && reg_wdata < (16'h0000 - {4'h0, `OSB_SON_LIMIT}))
                        servo_on_wait_time_q <= 12'h000 - `OSB_SON_LIMIT;
                    else
                        servo_on_wait_time_q <= reg_wdata[11:0];
                end
                `OSB_A_BASIC_WAIT: begin
                    basic_wait_time_q <= (reg_wdata[8:0] > `OSB_MAX_BASIC_WAIT || reg_wdata[15:9] != 7'h00)
                        ? `OSB_MAX_BASIC_WAIT : reg_wdata[8:0];
                end
                `OSB_A_BRK_SPEED: begin
                    if (reg_wdata[6:0] < `OSB_MIN_BRK_SPEED)
                        brake_wait_speed_q <= `OSB_MIN_BRK_SPEED;
                    else if (reg_wdata[6:0] > `OSB_MAX_BRK_SPEED || reg_wdata[15:7] != 9'h000)
                        brake_wait_speed_q <= `OSB_MAX_BRK_SPEED;
                    else
                        brake_wait_speed_q <= reg_wdata[6:0];
                end
                `OSB_A_BRK_TIME: begin
                    if (reg_wdata[6:0] < `OSB_MIN_BRK_TIME)
                        brake_wait_time_q <= `OSB_MIN_BRK_TIME;
                    else if (reg_wdata[6:0] > `OSB_MAX_BRK_TIME || reg_wdata[15:7] != 9'h000)
                        brake_wait_time_q <= `OSB_MAX_BRK_TIME;
                    else
                        brake_wait_time_q <= reg_wdata[6:0];
                end
                `OSB_A_BASIC_FUNC: basic_function_select_q <= reg_wdata[3:0];
                default: ;
            endcase
        end
    end

    // reads answer one cycle later; unmapped addresses read zero
    always @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `OSB_A_STOP_METHOD: reg_rdata <= {12'h000, stop_method_select_q};
                `OSB_A_PLUG_TORQUE: reg_rdata <= {7'h00, plug_brake_torque_limit_q};
                `OSB_A_OUT_ALLOC: reg_rdata <= {4'h0, output_function_alloc_q};
                `OSB_A_SON_WAIT: reg_rdata <= {{4{servo_on_wait_time_q[11]}}, servo_on_wait_time_q};
                `OSB_A_BASIC_WAIT: reg_rdata <= {7'h00, basic_wait_time_q};
                `OSB_A_BRK_SPEED: reg_rdata <= {9'h000, brake_wait_speed_q};
                `OSB_A_BRK_TIME: reg_rdata <= {9'h000, brake_wait_time_q};
                `OSB_A_BASIC_FUNC: reg_rdata <= {12'h000, basic_function_select_q};
                `OSB_A_STATUS: reg_rdata <= {4'h0, stop_method_act_q, 1'b0, state_q, power_loss_alarm,
                    brake_interlock_out, plug_brake, zero_clamp};
                `OSB_A_TORQUE_OUT: reg_rdata <= {7'h00, torque_limit_pct};
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // stop method writes: the whole word must be a legal code, else ignored;
    // no reset here, so a new method survives rst_n and waits for the next latch
    always @(posedge clock) begin
        if (rst_n && reg_wr && reg_addr == `OSB_A_STOP_METHOD) begin
            if (reg_wdata[15:4] == 12'h000 && reg_wdata[3:0] <= `OSB_SM_LAST)
                stop_method_select_q <= reg_wdata[3:0];
        end
    end

    // stop method in use is caught once, in the first clocked cycle after reset
    always @(posedge clock) begin
        if (!rst_n) begin
            boot_q <= 1'b1;
            stop_method_act_q <= `OSB_RST_STOP_METHOD;
        end else if (boot_q) begin
            boot_q <= 1'b0;
            stop_method_act_q <= stop_method_select_q;
        end
    end

    // stop sequencing and brake timing
    always @(posedge clock) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            wait_q <= 13'h0000;
            sub_q <= 10'h000;
            brake_hold_q <= 1'b1;
            power_loss_alarm <= 1'b0;
        end else begin
            // sticky until servo-on is asked again with no alarm
            if (main_power_lost && basic_function_select_q[`OSB_BF_PWRLOSS])
                power_loss_alarm <= 1'b1;
            else if (servo_on && !alarm_in)
                power_loss_alarm <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    brake_hold_q <= 1'b1;
                    if (servo_on && !alarm_in && !power_loss_alarm) begin
                        state_q <= ST_RUN;
                        brake_hold_q <= 1'b0;
                    end
                end
                ST_RUN: begin
                    brake_hold_q <= 1'b0;
                    wait_q <= 13'h0000;
                    sub_q <= 10'h000;
                    if (stop_req || power_loss_alarm)
                        state_q <= ST_SOFF_STOP;
                    else if (overtravel)
                        state_q <= ST_LIMIT_STOP;
                end
                ST_LIMIT_STOP: begin
                    // servo-off or alarm during a limit stop takes over
                    if (stop_req || power_loss_alarm)
                        state_q <= ST_SOFF_STOP;
                    else if (!overtravel)
                        state_q <= ST_RUN;
                    else if (motor_speed_rpm == 7'h00)
                        state_q <= to_clamp ? ST_CLAMP : ST_COAST;
                end
                ST_SOFF_STOP: begin
                    // brake applies when slow, or when the wait time runs out
                    if (tick_ms) begin
                        if (sub_q == `OSB_UNIT_MS_LAST) begin
                            sub_q <= 10'h000;
                            if (wait_q != 13'h1fff)
                                wait_q <= wait_q + 13'h0001;
                        end else begin
                            sub_q <= sub_q + 10'h001;
                        end
                    end
                    if ((wait_q >= {6'h00, brake_wait_time_q}) || slow)
                        brake_hold_q <= 1'b1;
                    if (wait_q >= {4'h0, basic_wait_time_q} && wait_q >= soff_wait_ms[12:0] / 13'h000a
                        && brake_hold_q && motor_speed_rpm == 7'h00)
                        state_q <= ST_COAST;
                end
                ST_COAST: begin
                    brake_hold_q <= 1'b1;
                    if (!stop_req && !power_loss_alarm && !overtravel)
                        state_q <= ST_RUN;
                end
                ST_CLAMP: begin
                    if (stop_req || power_loss_alarm)
                        state_q <= ST_SOFF_STOP;
                    else if (!overtravel)
                        state_q <= ST_RUN;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // power stage commands, registered
    always @(posedge clock) begin
        if (!rst_n) begin
            dynamic_brake <= 1'b0;
            power_enable <= 1'b0;
            plug_brake <= 1'b0;
            zero_clamp <= 1'b0;
            torque_limit_pct <= `OSB_RST_PLUG_TORQUE;
        end else begin
            dynamic_brake <= (state_q == ST_SOFF_STOP && soff_dyn) ||
                (state_q == ST_LIMIT_STOP && stop_method_act_q == `OSB_SM_DYN_COAST);
            power_enable <= (state_q == ST_RUN) || (state_q == ST_CLAMP) ||
                (state_q == ST_LIMIT_STOP && plug_mode);
            plug_brake <= (state_q == ST_LIMIT_STOP) && plug_mode;
            zero_clamp <= (state_q == ST_CLAMP);
            torque_limit_pct <= plug_brake_torque_limit_q;
        end
    end

    // output slot routing; a digit of F leaves the slot unused
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_slot
            wire [3:0] fn = output_function_alloc_q[4*g+3:4*g];
            always @(posedge clock) begin
                if (!rst_n)
                    slot_out_n[g] <= 1'b1;
                else if (fn == `OSB_FN_BRAKE)
                    slot_out_n[g] <= brake_hold_q;
                else if (fn < `OSB_FN_COUNT)
                    slot_out_n[g] <= !out_sources[fn];
                else
                    slot_out_n[g] <= 1'b1;
            end
        end
    endgenerate

    // brake interlock level: low releases, high applies
    always @(posedge clock) begin
        if (!rst_n)
            brake_interlock_out <= 1'b1;
        else
            brake_interlock_out <= brake_hold_q;
    end
endmodule

//--- tb/osb_checker_assertions.sv
// port checker for the stop sequencer, bound to osb_stop_sequencer
// assumes one clock and a synchronous active-low reset held for two edges
`timescale 1ns/1ps
module osb_checker (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // register writes
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    // drive state
    input wire forward_limit_input,
    input wire reverse_limit_input,
    input wire main_power_lost,
    input wire [6:0] motor_speed_rpm,
    // sequencer outputs
    input wire dynamic_brake,
    input wire power_enable,
    input wire plug_brake,
    input wire zero_clamp,
    input wire [8:0] torque_limit_pct,
    input wire power_loss_alarm,
    input wire [2:0] slot_out_n,
    input wire brake_interlock_out
);
    // method register survives reset, like a stored parameter
    reg [3:0] sm_q = 4'h0;
    reg [3:0] act_q;
    reg [11:0] alloc_q;
    reg [11:0] alloc_p_q;
    reg pwr_q;
    wire lim_w = forward_limit_input | reverse_limit_input;
    always @(posedge clock) begin
        alloc_p_q <= alloc_q;
        if (reg_wr && reg_addr == 4'h0 && reg_wdata <= 16'h0005)
            sm_q <= reg_wdata[3:0];
        if (!rst_n) begin
            act_q <= sm_q;
            alloc_q <= 12'hfff;
            pwr_q <= 1'b0;
        end else if (reg_wr && reg_addr == 4'h2)
            alloc_q <= reg_wdata[11:0];
        else if (reg_wr && reg_addr == 4'h7)
            pwr_q <= reg_wdata[3];
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    reset_outputs_a: assert property ($rose(rst_n) |-> brake_interlock_out && slot_out_n == 3'b111
        && torque_limit_pct == 9'h12c) else $error("outputs not at reset values");
    slots_unused_a: assert property (alloc_q == 12'hfff && alloc_p_q == 12'hfff |-> slot_out_n == 3'b111)
        else $error("unassigned slot driven");
    torque_write_a: assert property (reg_wr && reg_addr == 4'h1 |-> ##2 (($past(reg_wdata, 2) > 16'h012c) ?
        torque_limit_pct == 9'h12c : {7'h00, torque_limit_pct} == $past(reg_wdata, 2)))
        else $error("torque limit not applied");
    loss_alarm_a: assert property (pwr_q && main_power_lost |-> ##[1:3] power_loss_alarm)
        else $error("no alarm on power loss");
    loss_continue_a: assert property (!pwr_q |-> !$rose(power_loss_alarm))
        else $error("alarm while continue selected");
    limit_dyn_a: assert property ($rose(lim_w) && act_q == 4'h0 && power_enable && motor_speed_rpm != 7'h00
        |-> ##[1:3] dynamic_brake) else $error("no dynamic brake on overtravel");
    coast_only_a: assert property (act_q == 4'h1 |-> !dynamic_brake && !plug_brake)
        else $error("braking with coast method");
    limit_plug_a: assert property ($rose(lim_w) && act_q >= 4'h2 && power_enable && motor_speed_rpm != 7'h00
        |-> ##[1:3] plug_brake) else $error("no plug braking on overtravel");
    no_dynamic_a: assert property (act_q == 4'h3 || act_q == 4'h5 |-> !dynamic_brake)
        else $error("dynamic brake with coast servo-off");
    clamp_method_a: assert property (act_q <= 4'h3 |-> !zero_clamp)
        else $error("zero clamp with coast end state");
    clamp_powered_a: assert property (zero_clamp |-> power_enable && !dynamic_brake)
        else $error("zero clamp without power");
    brake_speed_a: assert property ($rose(brake_interlock_out) |-> motor_speed_rpm < 7'h64)
        else $error("brake applied above waiting speed");
endmodule
bind osb_stop_sequencer osb_checker u_osb_checker (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .forward_limit_input(forward_limit_input),
    .reverse_limit_input(reverse_limit_input), .main_power_lost(main_power_lost),
    .motor_speed_rpm(motor_speed_rpm), .dynamic_brake(dynamic_brake), .power_enable(power_enable),
    .plug_brake(plug_brake), .zero_clamp(zero_clamp), .torque_limit_pct(torque_limit_pct),
    .power_loss_alarm(power_loss_alarm), .slot_out_n(slot_out_n), .brake_interlock_out(brake_interlock_out));

//--- tb/osb_motor_model.sv
// motor, holding brake relay and power stage driven by the sequencer commands
// assumes one clock; speed moves each cycle by a step set by the commands
`timescale 1ns/1ps
module osb_motor_model (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // power stage commands
    input wire power_enable,
    input wire dynamic_brake,
    input wire plug_brake,
    input wire zero_clamp,
    input wire brake_interlock_out,
    // shaft speed magnitude
    output reg [6:0] motor_speed_rpm
);
    reg [6:0] step;
    wire drive_w = power_enable && !dynamic_brake && !plug_brake && !zero_clamp && !brake_interlock_out;
    always @* begin
        if (dynamic_brake)
            step = 7'h06;
        else if (plug_brake)
            step = 7'h08;
        else if (brake_interlock_out || zero_clamp)
            step = 7'h03;
        else
            step = 7'h01;
    end
    // coasting is slow on purpose so the waiting speed is crossed well after servo-off
    always @(posedge clock) begin
        if (!rst_n)
            motor_speed_rpm <= 7'h00;
        else if (drive_w)
            motor_speed_rpm <= (motor_speed_rpm >= 7'h76) ? 7'h78 : motor_speed_rpm + 7'h02;
        else
            motor_speed_rpm <= (motor_speed_rpm > step) ? motor_speed_rpm - step : 7'h00;
    end
endmodule

//--- tb/tb_osb_stop_sequencer.sv
// self-checking bench for the stop sequencer with the motor model on its power stage
// assumes the 25 MHz clock and the register offsets of the sequencer
`timescale 1ns/1ps
module tb_osb_stop_sequencer;
    reg clock = 1'b0;
    reg rst_n = 1'b0;
    reg [3:0] reg_addr = 4'h0;
    reg [15:0] reg_wdata = 16'h0000;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg servo_on = 1'b0;
    reg fwd_limit = 1'b0;
    reg rev_limit = 1'b0;
    reg pwr_lost = 1'b0;
    reg [11:0] out_sources = 12'h000;
    wire [15:0] reg_rdata;
    wire dynamic_brake, power_enable, plug_brake, zero_clamp, power_loss_alarm, brake_interlock_out;
    wire [8:0] torque_limit_pct;
    wire [2:0] slot_out_n;
    wire [6:0] motor_speed_rpm;
    int fails = 0;
    int cmp_count = 0;
    int n;
    int c;
    reg [15:0] d;
    always #20 clock = ~clock;
    osb_stop_sequencer u_osb_stop_sequencer (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .servo_on(servo_on), .alarm_in(1'b0),
        .forward_limit_input(fwd_limit), .reverse_limit_input(rev_limit), .main_power_lost(pwr_lost),
        .motor_speed_rpm(motor_speed_rpm), .out_sources(out_sources), .reg_rdata(reg_rdata),
        .dynamic_brake(dynamic_brake), .power_enable(power_enable), .plug_brake(plug_brake),
        .zero_clamp(zero_clamp), .torque_limit_pct(torque_limit_pct), .power_loss_alarm(power_loss_alarm),
        .slot_out_n(slot_out_n), .brake_interlock_out(brake_interlock_out));
    osb_motor_model u_osb_motor_model (.clock(clock), .rst_n(rst_n), .power_enable(power_enable),
        .dynamic_brake(dynamic_brake), .plug_brake(plug_brake), .zero_clamp(zero_clamp),
        .brake_interlock_out(brake_interlock_out), .motor_speed_rpm(motor_speed_rpm));
    task step;
        @(posedge clock) #1;
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input [3:0] a, input [15:0] v);
        @(posedge clock) reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clock) reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input [3:0] a);
        @(posedge clock) reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock) reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task rdc(input [3:0] a, input [15:0] e);
        rd(a);
        chk(d, e);
    endtask
    task do_reset;
        @(posedge clock) rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
    endtask
    task run;
        wr(4'h2, 16'h0724);
        @(posedge clock) servo_on <= 1'b1;
        for (n = 0; n < 200 && motor_speed_rpm !== 7'h78; n++) step;
        chk({brake_interlock_out, slot_out_n[0]}, 16'h0000);
    endtask
    task t_regs;
        chk({brake_interlock_out, slot_out_n, torque_limit_pct}, 16'h1f2c);
        rdc(4'h1, 16'h012c);
        rdc(4'h2, 16'h0fff);
        rdc(4'h3, 16'h0000);
        rdc(4'h4, 16'h0000);
        rdc(4'h5, 16'h0064);
        rdc(4'h6, 16'h0032);
        wr(4'hf, 16'h1234);
        rdc(4'hf, 16'h0000);
        wr(4'h3, 16'h0830);
        rdc(4'h3, 16'h07d0);
        wr(4'h3, 16'hf830);
        rdc(4'h3, 16'hf830);
        wr(4'h4, 16'h03e8);
        rdc(4'h4, 16'h01f4);
        wr(4'h6, 16'h0005);
        rdc(4'h6, 16'h000a);
        wr(4'h1, 16'h0064);
        step;
        chk(torque_limit_pct, 16'h0064);
        wr(4'h1, 16'h01f4);
        step;
        chk(torque_limit_pct, 16'h012c);
        $display("test regs done");
    endtask
    task t_alloc;
        for (c = 0; c < 12; c++) begin
            wr(4'h2, {8'h0f, c[3:0], 4'h4});
            @(posedge clock) out_sources <= 12'h001 << c;
            repeat (3) step;
            chk(slot_out_n, {1'b1, c == 4, 1'b1});
            @(posedge clock) out_sources <= ~(12'h001 << c);
            repeat (3) step;
            chk(slot_out_n, 16'h0007);
        end
        wr(4'h2, 16'h0fff);
        @(posedge clock) out_sources <= 12'hfff;
        repeat (3) step;
        chk(slot_out_n, 16'h0007);
        $display("test alloc done");
    endtask
    task t_codes;
        for (c = 0; c < 6; c++) begin
            wr(4'h0, c[15:0]);
            rd(4'h8);
            chk(d[11:8], (c == 0) ? 0 : c - 1);
            do_reset;
            rd(4'h8);
            chk(d[11:8], c[15:0]);
            run;
            @(posedge clock) servo_on <= 1'b0;
            for (n = 0; n < 40 && dynamic_brake !== 1'b1; n++) step;
            chk(dynamic_brake, !c[0]);
            for (n = 0; n < 300 && brake_interlock_out !== 1'b1; n++) step;
            chk(motor_speed_rpm < 7'h64, 16'h0001);
            for (n = 0; n < 300 && motor_speed_rpm != 7'h00; n++) step;
            run;
            @(posedge clock) fwd_limit <= !c[0];
            rev_limit <= c[0];
            for (n = 0; n < 40 && dynamic_brake !== 1'b1 && plug_brake !== 1'b1; n++) step;
            chk({dynamic_brake, plug_brake}, (c == 0) ? 2 : (c == 1) ? 0 : 1);
            chk(torque_limit_pct, 16'h012c);
            for (n = 0; n < 300 && motor_speed_rpm != 7'h00; n++) step;
            repeat (3) step;
            chk({zero_clamp, power_enable}, (c >= 4) ? 3 : 0);
            @(posedge clock) fwd_limit <= 1'b0;
            rev_limit <= 1'b0;
            servo_on <= 1'b0;
        end
        $display("test codes done");
    endtask
    task t_pwr;
        @(posedge clock) pwr_lost <= 1'b1;
        repeat (4) step;
        chk(power_loss_alarm, 16'h0000);
        @(posedge clock) pwr_lost <= 1'b0;
        wr(4'h7, 16'h0008);
        @(posedge clock) pwr_lost <= 1'b1;
        repeat (4) step;
        chk(power_loss_alarm, 16'h0001);
        @(posedge clock) pwr_lost <= 1'b0;
        $display("test power loss done");
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        do_reset;
        t_regs;
        t_alloc;
        t_codes;
        t_pwr;
        test_done;
    end
    // the tests need some 1500 cycles
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        test_done;
    end
endmodule
